// ---- logic/conv_ready_serial.sv ----
// Ready pin logic and serial shift port of the dual-channel converter
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/100ps
module conv_ready_serial
    import rdy_serial_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Serial link pins
    input rdy_serial_pkg::link_in_t link_i,
    output logic dout_o,
    output logic dout_oe_n_o,
    output logic rdy_n_o,
    // Converter events
    input rdy_serial_pkg::conv_evt_t conv_i,
    // Local register port
    input rdy_serial_pkg::lbus_req_t bus_i,
    output logic [7:0] rdata_o,
    // Converter control outputs
    output logic [7:0] mode_bits_o,
    output logic mode_start_o,
    output logic [7:0] ctrl_o,
    output logic [CAL_W-1:0] cal_coef_o,
    output logic [1:0] chan_en_o,
    output logic irq_o
);
    import rdy_serial_pkg::*;

    typedef enum logic [0:0] {PH_COMM, PH_DATA} phase_t;

    // ------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------
    link_in_t link_s;
    logic sclk_d_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic selected;

    pin_sync #(
        .W(3)
    ) u_sync (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .async_i(link_i),
        .sync_o(link_s)
    );

    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
            sclk_d_reg <= 1'b1;
        else
            sclk_d_reg <= link_s.sclk;
    end

    // Edges seen while deselected are ignored; a tied-low select always passes
    assign selected = !link_s.cs_n;
    assign sclk_rise = selected && link_s.sclk && !sclk_d_reg;
    assign sclk_fall = selected && !link_s.sclk && sclk_d_reg;

    // ------------------------------------------------------------
    // Serial framing
    // ------------------------------------------------------------
    phase_t phase_reg;
    logic [4:0] bit_cnt_reg;
    logic [3:0] sel_addr_reg;
    logic sel_rd_reg;
    logic [SHIFT_W-1:0] in_q;
    logic [SHIFT_W-1:0] out_q;
    logic [SHIFT_W-1:0] word_in;
    logic [SHIFT_W-1:0] view;
    logic word_end;
    logic comm_end;
    logic data_end;
    logic out_load;
    logic wr_mode;
    logic wr_ctrl;
    logic wr_cal;
    logic main_rd_done;
    logic aux_rd_done;

    logic main_flag_reg;
    logic aux_flag_reg;
    logic cal_hold_reg;
    logic [MAIN_W-1:0] main_data_reg;
    logic [AUX_W-1:0] aux_data_reg;
    logic [7:0] status_byte;

    function automatic logic [4:0] last_bit(input logic [3:0] a);
        case (a)
            SADDR_MAIN_DATA: last_bit = 5'(MAIN_W - 1);
            SADDR_AUX_DATA: last_bit = 5'(AUX_W - 1);
            SADDR_CAL: last_bit = 5'(CAL_W - 1);
            default: last_bit = 5'(BYTE_W - 1);
        endcase
    endfunction

    assign word_in = {in_q[SHIFT_W-2:0], link_s.din};
    assign word_end = sclk_rise &&
        (bit_cnt_reg == ((phase_reg == PH_COMM) ? 5'(BYTE_W - 1) : last_bit(sel_addr_reg)));
    assign comm_end = word_end && (phase_reg == PH_COMM);
    assign data_end = word_end && (phase_reg == PH_DATA);

    // Read view is left-aligned so the first bit out is always bit SHIFT_W-1
    always_comb
    begin
        status_byte = '0;
        status_byte[STAT_MAIN_BIT] = main_flag_reg;
        status_byte[STAT_AUX_BIT] = aux_flag_reg;
        status_byte[STAT_CAL_BIT] = cal_hold_reg;
        case (word_in[COMM_ADDR_LSB +: 4])
            SADDR_COMM_STAT: view = {status_byte, 16'h0000};
            SADDR_MODE: view = {mode_bits_o, 16'h0000};
            SADDR_CTRL: view = {ctrl_o, 16'h0000};
            SADDR_MAIN_DATA: view = main_data_reg;
            SADDR_AUX_DATA: view = {aux_data_reg, 8'h00};
            SADDR_CAL: view = cal_coef_o;
            default: view = '0;
        endcase
    end

    // A read command loads the output shifter from the selected register
    assign out_load = comm_end && word_in[COMM_RD_BIT];

    bit_shifter #(
        .W(SHIFT_W)
    ) u_in_shift (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .load_i(1'b0),
        .load_val_i('0),
        .shift_i(sclk_rise),
        .bit_i(link_s.din),
        .q_o(in_q)
    );

    bit_shifter #(
        .W(SHIFT_W)
    ) u_out_shift (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .load_i(out_load),
        .load_val_i(view),
        .shift_i(sclk_fall && (phase_reg == PH_DATA) && sel_rd_reg),
        .bit_i(1'b0),
        .q_o(out_q)
    );

    // Bit count survives pauses in the clock, so bursts join into one word
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i || link_s.cs_n)
        begin
            phase_reg <= PH_COMM;
            bit_cnt_reg <= '0;
            sel_addr_reg <= SADDR_COMM_STAT;
            sel_rd_reg <= 1'b0;
        end
        else if (word_end)
        begin
            bit_cnt_reg <= '0;
            case (phase_reg)
                PH_COMM:
                begin
                    sel_addr_reg <= word_in[COMM_ADDR_LSB +: 4];
                    sel_rd_reg <= word_in[COMM_RD_BIT];
                    // A write aimed at the communications register has no data phase
                    if (word_in[COMM_RD_BIT] || word_in[COMM_ADDR_LSB +: 4] != SADDR_COMM_STAT)
                        phase_reg <= PH_DATA;
                end
                PH_DATA: phase_reg <= PH_COMM;
                default: phase_reg <= PH_COMM;
            endcase
        end
        else if (sclk_rise)
            bit_cnt_reg <= bit_cnt_reg + 5'd1;
    end

    assign wr_mode = data_end && !sel_rd_reg && sel_addr_reg == SADDR_MODE;
    assign wr_ctrl = data_end && !sel_rd_reg && sel_addr_reg == SADDR_CTRL;
    assign wr_cal = data_end && !sel_rd_reg && sel_addr_reg == SADDR_CAL;
    assign main_rd_done = data_end && sel_rd_reg && sel_addr_reg == SADDR_MAIN_DATA;
    assign aux_rd_done = data_end && sel_rd_reg && sel_addr_reg == SADDR_AUX_DATA;

    // Data registers are read-only; writes to them are shifted in and dropped
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            mode_bits_o <= MODE_RST;
            ctrl_o <= CTRL_RST;
            cal_coef_o <= CAL_RST;
            mode_start_o <= 1'b0;
        end
        else
        begin
            mode_start_o <= wr_mode;
            if (wr_mode)
                mode_bits_o <= word_in[BYTE_W-1:0];
            if (wr_ctrl)
                ctrl_o <= word_in[BYTE_W-1:0];
            if (wr_cal)
                cal_coef_o <= word_in[CAL_W-1:0];
        end
    end

    // Output pin changes on the falling edge so the host samples a stable bit
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            dout_o <= 1'b1;
            dout_oe_n_o <= 1'b1;
        end
        else
        begin
            dout_oe_n_o <= link_s.cs_n;
            if (sclk_fall && phase_reg == PH_DATA && sel_rd_reg)
                dout_o <= out_q[SHIFT_W-1];
        end
    end

    // ------------------------------------------------------------
    // Channel ready flags
    // ------------------------------------------------------------
    logic main_set;
    logic aux_set;
    logic main_clr;
    logic aux_clr;

    // A disabled channel's conversions cannot raise its flag; the host clears a stale one by reading it
    assign main_set = (conv_i.main_done && chan_en_o[CHAN_MAIN_EN]) || conv_i.cal_done;
    assign aux_set = conv_i.aux_done && chan_en_o[CHAN_AUX_EN];
    assign main_clr = cal_hold_reg ? wr_mode : (main_rd_done || conv_i.update_warn);
    assign aux_clr = aux_rd_done || conv_i.update_warn;

    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            main_flag_reg <= 1'b0;
            aux_flag_reg <= 1'b0;
            cal_hold_reg <= 1'b0;
        end
        else
        begin
            main_flag_reg <= main_set || (main_flag_reg && !main_clr);
            aux_flag_reg <= aux_set || (aux_flag_reg && !aux_clr);
            cal_hold_reg <= conv_i.cal_done || (cal_hold_reg && !wr_mode);
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            main_data_reg <= '0;
            aux_data_reg <= '0;
        end
        else
        begin
            if (conv_i.main_done && chan_en_o[CHAN_MAIN_EN])
                main_data_reg <= conv_i.main_data;
            if (conv_i.aux_done && chan_en_o[CHAN_AUX_EN])
                aux_data_reg <= conv_i.aux_data;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
            rdy_n_o <= 1'b1;
        else
            rdy_n_o <= !(main_flag_reg || aux_flag_reg);
    end

    // ------------------------------------------------------------
    // Local registers and interrupt
    // ------------------------------------------------------------
    logic [EVT_W-1:0] evt_status_reg;
    logic [EVT_W-1:0] evt_enable_reg;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;

    assign evt_set = {data_end, conv_i.cal_done, aux_set, main_set && !conv_i.cal_done};
    assign evt_clr = (bus_i.wr && bus_i.addr == LREG_EVT_CLEAR) ? bus_i.wdata[EVT_W-1:0] : '0;

    // Set beats clear, so an event landing on a clear write is kept
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
            evt_status_reg <= '0;
        else
            evt_status_reg <= evt_set | (evt_status_reg & ~evt_clr);
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            evt_enable_reg <= EVT_EN_RST;
            chan_en_o <= CHAN_RST;
        end
        else if (bus_i.wr)
        begin
            if (bus_i.addr == LREG_EVT_ENABLE)
                evt_enable_reg <= bus_i.wdata[EVT_W-1:0];
            if (bus_i.addr == LREG_CHAN_CTRL)
                chan_en_o <= bus_i.wdata[1:0];
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
            rdata_o <= '0;
        else if (bus_i.rd)
        begin
            case (bus_i.addr)
                LREG_EVT_STATUS: rdata_o <= {4'h0, evt_status_reg};
                LREG_EVT_ENABLE: rdata_o <= {4'h0, evt_enable_reg};
                LREG_CHAN_CTRL: rdata_o <= {6'h00, chan_en_o};
                LREG_MODE_VIEW: rdata_o <= mode_bits_o;
                default: rdata_o <= '0;
            endcase
        end
        else
            rdata_o <= '0;
    end

    assign irq_o = |(evt_status_reg & evt_enable_reg);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_conv_sets_ready;
        @(posedge mclk_i) disable iff (!rstn_i)
        conv_i.main_done && chan_en_o[CHAN_MAIN_EN] |=> main_flag_reg ##1 !rdy_n_o;
    endproperty
    a_conv_sets_ready: assert property (p_conv_sets_ready)
        else $error("Conversion did not pull ready low");

    property p_read_releases;
        @(posedge mclk_i) disable iff (!rstn_i)
        main_rd_done && !cal_hold_reg && !main_set && !aux_flag_reg && !aux_set
            |-> ##2 rdy_n_o;
    endproperty
    a_read_releases: assert property (p_read_releases)
        else $error("Ready not released after data read");

    property p_warn_releases;
        @(posedge mclk_i) disable iff (!rstn_i)
        conv_i.update_warn && !cal_hold_reg && !main_set && !aux_set |=> !main_flag_reg && !aux_flag_reg;
    endproperty
    a_warn_releases: assert property (p_warn_releases)
        else $error("Flags not cleared before update");

    property p_cal_ready;
        @(posedge mclk_i) disable iff (!rstn_i)
        conv_i.cal_done |=> cal_hold_reg && main_flag_reg ##1 !rdy_n_o;
    endproperty
    a_cal_ready: assert property (p_cal_ready)
        else $error("Calibration end did not pull ready low");

    property p_ready_nor;
        @(posedge mclk_i) disable iff (!rstn_i)
        ##1 rdy_n_o == !($past(main_flag_reg) || $past(aux_flag_reg));
    endproperty
    a_ready_nor: assert property (p_ready_nor)
        else $error("Ready pin is not NOR of channel flags");

    property p_disabled_quiet;
        @(posedge mclk_i) disable iff (!rstn_i)
        !aux_flag_reg && !chan_en_o[CHAN_AUX_EN] |=> !aux_flag_reg;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("Disabled channel raised its flag");

    property p_cal_hold;
        @(posedge mclk_i) disable iff (!rstn_i)
        cal_hold_reg && !wr_mode |=> main_flag_reg && cal_hold_reg;
    endproperty
    a_cal_hold: assert property (p_cal_hold)
        else $error("Ready released after calibration without mode write");

    property p_ctrl_write;
        @(posedge mclk_i) disable iff (!rstn_i)
        data_end && !sel_rd_reg && sel_addr_reg == SADDR_CTRL
            |=> ctrl_o == $past(word_in[BYTE_W-1:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("Control register missed shifted-in data");

    property p_release_dout;
        @(posedge mclk_i) disable iff (!rstn_i)
        link_s.cs_n |=> dout_oe_n_o;
    endproperty
    a_release_dout: assert property (p_release_dout)
        else $error("Serial output driven while deselected");

    property p_reset_state;
        @(posedge mclk_i)
        !rstn_i |=> rdy_n_o && !main_flag_reg && !aux_flag_reg && phase_reg == PH_COMM;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("Reset did not restore idle state");

endmodule

// ---- logic/rdy_serial_pkg.sv ----
// Constants, field positions and carrier types for the ready pin and serial port block
//
// Overview of operation
// - Ready low while any channel holds unread data
// - Completed data register read returns ready high
// - Unread result: ready high before next update
// - Calibration completion drives ready low
// - Ready pin is NOR of channel flags
// - Disabled channel no longer sets its flag
// - Ready held low after calibration until mode write
// - Output shifter loads any selected readable register
// - Shifted-in data goes to communications-selected register
// - Device select active low, may be tied low
// - Serial clock continuous or in separate bursts
// - Reset restores flags and interface to power-on
package rdy_serial_pkg;

    // ------------------------------------------------------------
    // Serial register selection and widths
    // ------------------------------------------------------------
    localparam logic [3:0] SADDR_COMM_STAT = 4'h0;
    localparam logic [3:0] SADDR_MODE = 4'h1;
    localparam logic [3:0] SADDR_CTRL = 4'h2;
    localparam logic [3:0] SADDR_MAIN_DATA = 4'h3;
    localparam logic [3:0] SADDR_AUX_DATA = 4'h4;
    localparam logic [3:0] SADDR_CAL = 4'h5;
    localparam int SHIFT_W = 24;
    localparam int BYTE_W = 8;
    localparam int MAIN_W = 24;
    localparam int AUX_W = 16;
    localparam int CAL_W = 24;
    localparam int COMM_RD_BIT = 6;
    localparam int COMM_ADDR_LSB = 0;
    localparam int STAT_MAIN_BIT = 0;
    localparam int STAT_AUX_BIT = 1;
    localparam int STAT_CAL_BIT = 2;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [23:0] CAL_RST = 24'h00_0000;

    // ------------------------------------------------------------
    // Local register port
    // ------------------------------------------------------------
    localparam logic [3:0] LREG_EVT_STATUS = 4'h0;
    localparam logic [3:0] LREG_EVT_CLEAR = 4'h1;
    localparam logic [3:0] LREG_EVT_ENABLE = 4'h2;
    localparam logic [3:0] LREG_CHAN_CTRL = 4'h3;
    localparam logic [3:0] LREG_MODE_VIEW = 4'h4;
    localparam int EVT_W = 4;
    localparam int EVT_MAIN = 0;
    localparam int EVT_AUX = 1;
    localparam int EVT_CAL = 2;
    localparam int EVT_FRAME = 3;
    localparam int CHAN_MAIN_EN = 0;
    localparam int CHAN_AUX_EN = 1;
    localparam logic [1:0] CHAN_RST = 2'h3;
    localparam logic [3:0] EVT_EN_RST = 4'h0;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic din;
    } link_in_t;

    typedef struct packed {
        logic main_done;
        logic aux_done;
        logic update_warn;
        logic cal_done;
        logic [MAIN_W-1:0] main_data;
        logic [AUX_W-1:0] aux_data;
    } conv_evt_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } lbus_req_t;

endpackage

// ---- logic/pin_sync.sv ----
// Two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 3
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Pins
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_reg;

    initial
    begin
        if (W < 1)
            $error("pin_sync: W must be at least 1");
    end

    // Pull-ups make idle pins high, so reset to ones
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
        begin
            meta_reg <= '1;
            sync_o <= '1;
        end
        else
        begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end
endmodule

// ---- logic/bit_shifter.sv ----
// Parallel-load shift register, shifting toward the most significant bit
`timescale 1ns/100ps
module bit_shifter #(
    parameter int W = 24
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Control
    input wire logic load_i,
    input wire logic [W-1:0] load_val_i,
    input wire logic shift_i,
    input wire logic bit_i,
    // State
    output logic [W-1:0] q_o
);
    initial
    begin
        if (W < 2)
            $error("bit_shifter: W must be at least 2");
    end

    // Load has priority so a new word never mixes with an old tail
    always_ff @(posedge mclk_i)
    begin
        if (!rstn_i)
            q_o <= '0;
        else if (load_i)
            q_o <= load_val_i;
        else if (shift_i)
            q_o <= {q_o[W-2:0], bit_i};
    end
endmodule

// ---- bench/host_link_model.sv ----
// Host-side serial master model that drives the link pins of the block
`timescale 1ns/100ps
module host_link_model
    import rdy_serial_pkg::*;
(
    input wire logic mclk_i,
    output rdy_serial_pkg::link_in_t link_o,
    input wire logic dout_i,
    input wire logic dout_oe_n_i
);
    // Idle: clock parked high, data pulled up, device not selected
    initial link_o = 3'b111;

    task automatic wait_clk(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // One bit in 800 ns: fall and present data, sample output just before the rise
    task automatic bit_xfer(input logic b, output logic r);
        link_o.sclk <= 1'b0;
        link_o.din <= b;
        wait_clk(4);
        // A released output never passes for data
        r = dout_oe_n_i ? 1'bx : dout_i;
        link_o.sclk <= 1'b1;
        wait_clk(4);
    endtask

    // ------------------------------------------------------------
    // Whole frame: command byte, optional pause, then the data word
    // ------------------------------------------------------------
    task automatic xfer(input logic [7:0] comm, input int n, input logic [23:0] wd,
                        input int gap, output logic [23:0] rd);
        logic r;
        link_o.cs_n <= 1'b0;
        wait_clk(3);
        for (int i = 7; i >= 0; i--)
        begin
            bit_xfer(comm[i], r);
        end
        // Clock stands still between bursts
        wait_clk(gap);
        rd = 24'h00_0000;
        for (int i = n - 1; i >= 0; i--)
        begin
            bit_xfer(wd[i], r);
            rd[i] = r;
        end
        wait_clk(3);
        link_o.cs_n <= 1'b1;
        link_o.din <= 1'b1;
        wait_clk(4);
    endtask

    // Deselect in the middle of a command byte
    task automatic abort_frame;
        logic r;
        link_o.cs_n <= 1'b0;
        wait_clk(3);
        bit_xfer(1'b0, r);
        bit_xfer(1'b1, r);
        bit_xfer(1'b0, r);
        link_o.cs_n <= 1'b1;
        link_o.din <= 1'b1;
        wait_clk(4);
    endtask
endmodule

// ---- bench/tb_conv_ready_serial.sv ----
// Self-checking bench for the ready pin and serial port block
`timescale 1ns/100ps
module tb_conv_ready_serial;
    import rdy_serial_pkg::*;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    link_in_t link;
    conv_evt_t conv = '0;
    lbus_req_t bus = '0;
    logic dout_o, dout_oe_n_o, rdy_n_o, mode_start_o, irq_o;
    logic [7:0] rdata_o, mode_bits_o, ctrl_o, b;
    logic [CAL_W-1:0] cal_coef_o;
    logic [1:0] chan_en_o;
    logic [23:0] rd, val;
    int errors = 0;
    int comparisons = 0;
    int starts = 0;
    int mf = 0;
    int af = 0;

    always #50 mclk_i = ~mclk_i;
    always @(posedge mclk_i)
        if (mode_start_o === 1'b1) starts <= starts + 1;

    conv_ready_serial conv_ready_serial_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
        .link_i(link), .dout_o(dout_o), .dout_oe_n_o(dout_oe_n_o), .rdy_n_o(rdy_n_o),
        .conv_i(conv), .bus_i(bus), .rdata_o(rdata_o), .mode_bits_o(mode_bits_o),
        .mode_start_o(mode_start_o), .ctrl_o(ctrl_o), .cal_coef_o(cal_coef_o),
        .chan_en_o(chan_en_o), .irq_o(irq_o));
    host_link_model host_link_model_inst (.mclk_i(mclk_i), .link_o(link),
        .dout_i(dout_o), .dout_oe_n_i(dout_oe_n_o));

    task automatic end_of_test;
        if (errors == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Ready pin against the flag model: low while either flag is set
    task automatic chk_rdy;
        tick(4);
        chk({23'h0, rdy_n_o}, {23'h0, !(mf != 0 || af != 0)});
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        tick(1);
        bus <= '0;
        tick(1);
    endtask

    task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        tick(1);
        bus <= '0;
        #1 d = rdata_o;
        tick(1);
    endtask

    // Converter pulses: bit0 main, bit1 aux, bit2 update warning, bit3 calibration
    task automatic evt(input logic [3:0] s);
        conv <= '{main_done: s[0], aux_done: s[1], update_warn: s[2], cal_done: s[3],
                  main_data: val, aux_data: val[15:0]};
        tick(1);
        conv <= '0;
        tick(1);
    endtask

    initial
    begin
        tick(40000);
        errors++;
        end_of_test;
    end

    initial
    begin
        val = 24'($urandom(59));
        tick(12);
        rstn_i <= 1'b1;
        tick(3);
        chk({17'h0, dout_o, dout_oe_n_o, rdy_n_o, irq_o, mode_start_o, chan_en_o}, 24'h73);
        chk({rdata_o, mode_bits_o, ctrl_o}, 24'h0);
        chk(cal_coef_o, 24'h0);
        // ------------------------------------------------------------
        // Main result, event interrupt, read with a paused clock
        // ------------------------------------------------------------
        bus_wr(LREG_EVT_ENABLE, 8'h01);
        val = 24'($urandom);
        evt(4'h1);
        mf = 1;
        chk_rdy;
        chk({23'h0, irq_o}, 24'h1);
        bus_rd(LREG_EVT_STATUS, b);
        chk({16'h0, b & 8'h01}, 24'h1);
        host_link_model_inst.xfer(8'h43, 24, 24'h0, 20, rd);
        mf = 0;
        chk(rd, val);
        chk_rdy;
        chk({23'h0, dout_oe_n_o}, 24'h1);
        bus_wr(LREG_EVT_CLEAR, 8'h0f);
        chk({23'h0, irq_o}, 24'h0);
        bus_rd(LREG_EVT_CLEAR, b);
        chk({16'h0, b}, 24'h0);
        bus_rd(4'hf, b);
        chk({16'h0, b}, 24'h0);
        bus_wr(LREG_EVT_ENABLE, 8'h00);
        // ------------------------------------------------------------
        // Both channels, then warning before an update
        // ------------------------------------------------------------
        val = 24'($urandom);
        evt(4'h3);
        mf = 1;
        af = 1;
        chk({23'h0, irq_o}, 24'h0);
        host_link_model_inst.xfer(8'h44, 16, 24'h0, 0, rd);
        af = 0;
        chk(rd, {8'h0, val[15:0]});
        chk_rdy;
        evt(4'h4);
        mf = 0;
        chk_rdy;
        // ------------------------------------------------------------
        // Calibration holds ready until a mode write
        // ------------------------------------------------------------
        bus_wr(LREG_EVT_CLEAR, 8'h0f);
        evt(4'h8);
        mf = 1;
        chk_rdy;
        bus_rd(LREG_EVT_STATUS, b);
        chk({16'h0, b}, 24'h4);
        evt(4'h4);
        host_link_model_inst.xfer(8'h43, 24, 24'h0, 0, rd);
        chk_rdy;
        // Status byte during the hold: calibration hold and main flag set
        host_link_model_inst.xfer(8'h40, 8, 24'h0, 0, rd);
        chk(rd, 24'h5);
        b = 8'($urandom);
        host_link_model_inst.xfer(8'h01, 8, {16'h0, b}, 0, rd);
        mf = 0;
        chk_rdy;
        chk({8'h0, mode_bits_o, 8'(starts)}, {8'h0, b, 8'h01});
        val[7:0] = b;
        bus_rd(LREG_MODE_VIEW, b);
        chk({16'h0, b}, {16'h0, val[7:0]});
        // ------------------------------------------------------------
        // Control and calibration writes, aborted frame, read back
        // ------------------------------------------------------------
        val = 24'($urandom);
        host_link_model_inst.xfer(8'h02, 8, {16'h0, val[7:0]}, 0, rd);
        host_link_model_inst.xfer(8'h05, 24, ~val, 0, rd);
        chk({16'h0, ctrl_o}, {16'h0, val[7:0]});
        chk(cal_coef_o, ~val);
        host_link_model_inst.abort_frame;
        host_link_model_inst.xfer(8'h42, 8, 24'h0, 0, rd);
        chk(rd, {16'h0, val[7:0]});
        // ------------------------------------------------------------
        // Disabled auxiliary channel
        // ------------------------------------------------------------
        evt(4'h2);
        af = 1;
        bus_wr(LREG_CHAN_CTRL, 8'h01);
        chk({22'h0, chan_en_o}, 24'h1);
        host_link_model_inst.xfer(8'h44, 16, 24'h0, 0, rd);
        af = 0;
        chk_rdy;
        evt(4'h2);
        chk_rdy;
        evt(4'h1);
        mf = 1;
        chk_rdy;
        host_link_model_inst.xfer(8'h43, 24, 24'h0, 0, rd);
        mf = 0;
        chk_rdy;
        // ------------------------------------------------------------
        // Reset in mid-run with a flag set and registers written
        // ------------------------------------------------------------
        evt(4'h1);
        rstn_i <= 1'b0;
        tick(3);
        rstn_i <= 1'b1;
        chk_rdy;
        chk({13'h0, irq_o, mode_bits_o, chan_en_o}, 24'h3);
        chk(cal_coef_o, 24'h0);
        end_of_test;
    end
endmodule
